// ### include/sbsync_pkg.sv
package sbsync_pkg;

    // register byte addresses
    localparam logic [15:0] ADDR_CTRL_PRIMARY = 16'hF078;
    localparam logic [15:0] ADDR_CTRL_PINS = 16'hF079;
    localparam logic [15:0] ADDR_MODE = 16'hF07A;
    localparam logic [15:0] ADDR_STATUS = 16'hF07C;
    localparam logic [15:0] ADDR_FORMAT = 16'hF07D;
    localparam logic [15:0] ADDR_TX_BUF = 16'hF07E;
    localparam logic [15:0] ADDR_RX_BUF = 16'hF07F;

    // field positions
    localparam int unsigned BIT_SDA_LEVEL = 5;
    localparam int unsigned BIT_SDA_PROTECT = 4;
    localparam int unsigned BIT_SCL_MON = 3;
    localparam int unsigned BIT_ORDER = 7;
    localparam int unsigned BIT_FORMAT = 0;
    localparam int unsigned BIT_TX_EMPTY = 7;
    localparam int unsigned BIT_TX_END = 6;
    localparam int unsigned BIT_RX_FULL = 5;
    localparam int unsigned BIT_BUSY = 0;

    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_TX_BUF = 8'hFF;
    localparam logic [7:0] RST_RX_BUF = 8'h00;
    localparam logic RST_SDA_LEVEL = 1'b1;
    localparam logic RST_ORDER = 1'b0;
    localparam logic RST_FORMAT = 1'b0;

    // transfer clock
    localparam logic [3:0] CLK_SEL_DIV100 = 4'h5;
    localparam int unsigned DIV_RATIO_100 = 100;
    localparam int unsigned BITS_PER_FRAME = 8;

    typedef struct packed {
        logic enable;
        logic rx_inhibit;
        logic master;
        logic transmit;
        logic [3:0] clk_sel;
    } sbsync_ctrl_t;

    typedef enum logic [3:0] {
        MODE_SLAVE_RX = 4'b0001,
        MODE_SLAVE_TX = 4'b0010,
        MODE_MASTER_RX = 4'b0100,
        MODE_MASTER_TX = 4'b1000
    } sbsync_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_FINISH = 3'b100
    } sbsync_state_t;

endpackage

// ### rtl/sbsync_top.sv
`timescale 1ns/1ps
// Behaviour
// - enable 0 halts engine and releases pins; enable 1 lets the block drive them
// - in master receive a receive-buffer read starts next reception unless inhibited; slave receive starts whenever idle
// - master and transmit bits decode to slave rx, slave tx, master rx, master tx
// - clock select field sets the serial clock only in master mode
// - clock select 0101 gives system clock divided by 100
// - data-line level bit reads 0 while pin driven low, 1 otherwise
// - outside frames, writing level 0 drives data pin low; 1 releases it to the pull-up
// - level bit written only with protect bit 0; protect bit reads 1
// - bit order 0 shifts msb first, 1 shifts lsb first
// - format 0 selects addressed bus protocol, 1 selects clocked serial format
// - transmit buffer moves to shift register when free; new write allows back-to-back
// - each received byte is copied to the read-only receive buffer
module sbsync_top #(
    parameter int unsigned OTHER_DIV_RATIO = 100
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // register port
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // serial clock pin
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe,
    // serial data pin
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // status
    output sbsync_pkg::sbsync_mode_t o_mode,
    output logic o_busy
);
    import sbsync_pkg::*;

    localparam logic [7:0] HALF_DIV100 = 8'(DIV_RATIO_100 / 2 - 1);
    localparam logic [7:0] HALF_OTHER = 8'(OTHER_DIV_RATIO / 2 - 1);
    localparam logic [2:0] LAST_BIT = 3'(BITS_PER_FRAME - 1);

    function automatic sbsync_mode_t decode_mode(input logic master, input logic transmit);
        sbsync_mode_t m;
        case ({master, transmit})
            2'b00: m = MODE_SLAVE_RX;
            2'b01: m = MODE_SLAVE_TX;
            2'b10: m = MODE_MASTER_RX;
            default: m = MODE_MASTER_TX;
        endcase
        return m;
    endfunction

    function automatic logic [7:0] half_count(input logic [3:0] sel);
        return (sel == CLK_SEL_DIV100) ? HALF_DIV100 : HALF_OTHER;
    endfunction

    // registers
    sbsync_ctrl_t ctrl_r;
    logic lsb_first_r;
    logic format_sync_r;
    logic sda_level_r;
    logic [7:0] tx_buf_r;
    logic tx_full_r;
    logic [7:0] rx_buf_r;
    logic rx_full_r;
    logic tx_end_r;
    logic rx_go_r;
    logic [7:0] rdata_r;

    // engine
    sbsync_state_t state_r;
    sbsync_state_t state_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    logic [7:0] div_cnt_r;
    logic [7:0] div_cnt_nxt;
    logic scl_low_r;
    logic scl_low_nxt;
    logic active_tx_r;
    logic active_tx_nxt;
    logic sda_low_r;
    logic scl_oe_r;
    sbsync_mode_t mode_r;

    // pin synchronisers
    logic scl_meta_r;
    logic scl_sync_r;
    logic scl_prev_r;
    logic sda_meta_r;
    logic sda_sync_r;

    // bus decode
    wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL_PRIMARY);
    wire wr_pins = i_wr && (i_addr == ADDR_CTRL_PINS);
    wire wr_mode = i_wr && (i_addr == ADDR_MODE);
    wire wr_status = i_wr && (i_addr == ADDR_STATUS);
    wire wr_format = i_wr && (i_addr == ADDR_FORMAT);
    wire wr_tx = i_wr && (i_addr == ADDR_TX_BUF);
    wire rd_rx = i_rd && (i_addr == ADDR_RX_BUF);

    // engine only runs enabled and in clocked serial format
    wire run = ctrl_r.enable && format_sync_r;
    wire idle = (state_r == ST_IDLE);
    wire is_master = ctrl_r.master;
    wire tick = (div_cnt_r == 8'h00);

    // master clock is internal; slave follows the synchronised pin
    wire m_rise = is_master && tick && scl_low_r && (state_r == ST_SHIFT);
    wire m_fall = is_master && tick && !scl_low_r && (state_r == ST_SHIFT);
    wire s_rise = !is_master && scl_sync_r && !scl_prev_r;
    wire s_fall = !is_master && !scl_sync_r && scl_prev_r;
    wire rise_evt = m_rise || (s_rise && (state_r == ST_SHIFT));
    wire fall_evt = m_fall || (s_fall && (state_r == ST_SHIFT));

    wire out_bit = lsb_first_r ? shift_r[0] : shift_r[7];
    wire [7:0] shift_out = lsb_first_r ? {1'b0, shift_r[7:1]} : {shift_r[6:0], 1'b0};
    wire [7:0] shift_in = lsb_first_r ? {sda_sync_r, shift_r[7:1]}
                                      : {shift_r[6:0], sda_sync_r};

    // frame starts
    wire start_tx = run && idle && ctrl_r.transmit && tx_full_r;
    wire start_rx = run && idle && !ctrl_r.transmit && (!is_master || rx_go_r);
    wire finish_now = (state_r == ST_FINISH) && (!is_master || tick);
    wire rx_done = finish_now && !active_tx_r;
    wire tx_done = finish_now && active_tx_r;

    // next-state logic of the shift engine
    always_comb
    begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        div_cnt_nxt = (tick || idle) ? half_count(ctrl_r.clk_sel) : div_cnt_r - 8'h01;
        scl_low_nxt = scl_low_r;
        active_tx_nxt = active_tx_r;
        case (state_r)
            ST_IDLE:
            begin
                scl_low_nxt = 1'b0;
                if (start_tx || start_rx)
                begin
                    state_nxt = ST_SHIFT;
                    shift_nxt = start_tx ? tx_buf_r : 8'h00;
                    bit_cnt_nxt = 3'h0;
                    scl_low_nxt = is_master;
                    active_tx_nxt = start_tx;
                end
            end
            ST_SHIFT:
            begin
                if (is_master && tick)
                begin
                    scl_low_nxt = !scl_low_r;
                end
                if (rise_evt)
                begin
                    if (!active_tx_r)
                    begin
                        shift_nxt = shift_in;
                    end
                    bit_cnt_nxt = bit_cnt_r + 3'h1;
                    if (bit_cnt_r == LAST_BIT)
                    begin
                        state_nxt = ST_FINISH;
                    end
                end
                else if (fall_evt && active_tx_r && (bit_cnt_r != 3'h0))
                begin
                    shift_nxt = shift_out;
                end
            end
            ST_FINISH:
            begin
                // master keeps the last high half before closing the frame
                if (finish_now)
                begin
                    state_nxt = ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!run)
        begin
            state_nxt = ST_IDLE;
            scl_low_nxt = 1'b0;
        end
    end

    // pin drive values
    wire frame_on = !idle;
    wire sda_low_nxt = ctrl_r.enable && ((frame_on && run) ? (active_tx_r && !out_bit)
                                                           : !sda_level_r);
    wire scl_oe_nxt = run && is_master && scl_low_nxt;

    // read mux
    wire [7:0] pins_rd = {2'b00, !sda_low_r, 1'b1, scl_sync_r, 3'b000};
    wire [7:0] mode_rd = {lsb_first_r, 4'h0, bit_cnt_r};
    wire [7:0] status_rd = {!tx_full_r, tx_end_r, rx_full_r, 4'h0, frame_on};
    wire [7:0] rd_mux =
        (i_addr == ADDR_CTRL_PRIMARY) ? ctrl_r :
        (i_addr == ADDR_CTRL_PINS) ? pins_rd :
        (i_addr == ADDR_MODE) ? mode_rd :
        (i_addr == ADDR_STATUS) ? status_rd :
        (i_addr == ADDR_FORMAT) ? {7'h00, format_sync_r} :
        (i_addr == ADDR_TX_BUF) ? tx_buf_r :
        (i_addr == ADDR_RX_BUF) ? rx_buf_r : 8'h00;

    // pin synchronisers
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_meta_r <= 1'b1;
            scl_sync_r <= 1'b1;
            scl_prev_r <= 1'b1;
            sda_meta_r <= 1'b1;
            sda_sync_r <= 1'b1;
        end
        else
        begin
            scl_meta_r <= i_scl;
            scl_sync_r <= scl_meta_r;
            scl_prev_r <= scl_sync_r;
            sda_meta_r <= i_sda;
            sda_sync_r <= sda_meta_r;
        end
    end

    // software registers
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_r <= sbsync_ctrl_t'(RST_CTRL);
            lsb_first_r <= RST_ORDER;
            format_sync_r <= RST_FORMAT;
            sda_level_r <= RST_SDA_LEVEL;
            tx_buf_r <= RST_TX_BUF;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= sbsync_ctrl_t'(i_wdata);
            end
            if (wr_pins && !i_wdata[BIT_SDA_PROTECT])
            begin
                sda_level_r <= i_wdata[BIT_SDA_LEVEL];
            end
            if (wr_mode)
            begin
                // counter bits are engine-owned and ignore writes
                lsb_first_r <= i_wdata[BIT_ORDER];
            end
            if (wr_format)
            begin
                format_sync_r <= i_wdata[BIT_FORMAT];
            end
            if (wr_tx)
            begin
                tx_buf_r <= i_wdata;
            end
        end
    end

    // hardware-set flags; a set always beats a clear in the same cycle
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_full_r <= 1'b0;
            tx_end_r <= 1'b0;
            rx_full_r <= 1'b0;
            rx_go_r <= 1'b0;
            rx_buf_r <= RST_RX_BUF;
        end
        else
        begin
            tx_full_r <= wr_tx || (tx_full_r && !start_tx);
            tx_end_r <= (tx_done && !tx_full_r)
                     || (tx_end_r && !wr_tx && !(wr_status && !i_wdata[BIT_TX_END]));
            rx_full_r <= rx_done || (rx_full_r && !rd_rx);
            rx_go_r <= (rd_rx && !ctrl_r.transmit && !ctrl_r.rx_inhibit)
                    || (rx_go_r && !(start_rx && is_master) && run);
            if (rx_done)
            begin
                rx_buf_r <= shift_r;
            end
        end
    end

    // engine state
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            div_cnt_r <= 8'h00;
            scl_low_r <= 1'b0;
            active_tx_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            div_cnt_r <= div_cnt_nxt;
            scl_low_r <= scl_low_nxt;
            active_tx_r <= active_tx_nxt;
        end
    end

    // registered outputs
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sda_low_r <= 1'b0;
            scl_oe_r <= 1'b0;
            mode_r <= MODE_SLAVE_RX;
            rdata_r <= 8'h00;
        end
        else
        begin
            sda_low_r <= sda_low_nxt;
            scl_oe_r <= scl_oe_nxt;
            mode_r <= decode_mode(ctrl_r.master, ctrl_r.transmit);
            rdata_r <= i_rd ? rd_mux : 8'h00;
        end
    end

    // open-drain pins: only ever pull low
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_low_r;
    assign o_scl = 1'b0;
    assign o_scl_oe = scl_oe_r;
    assign o_rdata = rdata_r;
    assign o_mode = mode_r;
    assign o_busy = frame_on;

endmodule // sbsync_top

// ### tb/sbsync_top_chk.sv
`timescale 1ns/1ps
module sbsync_top_chk
    import sbsync_pkg::*;
#(
    parameter int unsigned OTHER_DIV_RATIO = 100
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // register port
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // pins and status
    input wire logic o_scl_oe,
    input wire logic o_sda_oe,
    input wire sbsync_pkg::sbsync_mode_t o_mode,
    input wire logic o_busy
);
    logic [7:0] ctrl_r;
    logic [7:0] hi_r;
    logic [3:0] nrise_r;
    wire ctrl_wr = i_wr && (i_addr == ADDR_CTRL_PRIMARY);
    wire [7:0] half_exp = (ctrl_r[3:0] == CLK_SEL_DIV100) ? 8'(DIV_RATIO_100 / 2)
        : 8'(OTHER_DIV_RATIO / 2);

    // shadow of the control byte, since only the ports are visible here
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_r <= RST_CTRL;
            hi_r <= 8'h00;
            nrise_r <= 4'h0;
        end
        else
        begin
            ctrl_r <= ctrl_wr ? i_wdata : ctrl_r;
            hi_r <= o_scl_oe ? hi_r + 8'h01 : 8'h00;
            nrise_r <= (!o_busy && !o_scl_oe) ? 4'h0 : nrise_r + 4'($rose(o_scl_oe));
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_idle2;
        !o_busy ##1 !o_busy;
    endsequence
    sequence s_off2;
        !ctrl_r[7] ##1 !ctrl_r[7];
    endsequence
    sequence s_slave2;
        !ctrl_r[5] ##1 !ctrl_r[5];
    endsequence

    property p_mode_decode;
        ctrl_wr |-> ##2 (o_mode == sbsync_mode_t'(4'h1 << $past(ctrl_r[5:4])));
    endproperty
    property p_protect_read;
        $past(i_rd) && ($past(i_addr) == ADDR_CTRL_PINS) |-> o_rdata[BIT_SDA_PROTECT];
    endproperty
    property p_disable_release;
        s_off2 |-> !o_scl_oe && !o_sda_oe;
    endproperty
    property p_scl_idle;
        s_idle2 |-> !o_scl_oe;
    endproperty
    property p_slave_no_scl;
        s_slave2 |-> !o_scl_oe;
    endproperty
    property p_half_period;
        $fell(o_scl_oe) && ctrl_r[5] |-> hi_r == half_exp;
    endproperty
    property p_frame_bits;
        $fell(o_busy) && ctrl_r[5] |-> nrise_r == 4'h8;
    endproperty
    property p_sda_hold;
        ctrl_r[5] && ctrl_r[4] && o_busy && !o_scl_oe && !$past(o_scl_oe) |-> $stable(o_sda_oe);
    endproperty

    a_mode_decode: assert property (p_mode_decode)
        else $error("mode output does not match control write");
    a_protect_read: assert property (p_protect_read)
        else $error("write protect bit read back as 0");
    a_disable_release: assert property (p_disable_release)
        else $error("pin driven while block disabled");
    a_scl_idle: assert property (p_scl_idle)
        else $error("serial clock driven outside a frame");
    a_slave_no_scl: assert property (p_slave_no_scl)
        else $error("serial clock driven in slave mode");
    a_half_period: assert property (p_half_period)
        else $error("serial clock low half has wrong length");
    a_frame_bits: assert property (p_frame_bits)
        else $error("frame did not carry eight clocks");
    a_sda_hold: assert property (p_sda_hold)
        else $error("data changed while serial clock high");
endmodule // sbsync_top_chk

bind sbsync_top sbsync_top_chk #(.OTHER_DIV_RATIO(OTHER_DIV_RATIO)) u_chk (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_scl_oe(o_scl_oe),
    .o_sda_oe(o_sda_oe),
    .o_mode(o_mode),
    .o_busy(o_busy)
);

// ### tb/sbsync_peer.sv
`timescale 1ns/1ps
module sbsync_peer (
    // wire side
    input wire logic i_scl,
    input wire logic i_sda,
    // bench side
    input wire logic i_load,
    input wire logic [7:0] i_tx,
    output logic o_sda_oe,
    output logic [15:0] o_rx,
    output int o_nbits
);
    logic [7:0] tx_sr_r = 8'hFF;
    initial o_sda_oe = 1'b0;
    initial o_rx = 16'h0000;
    initial o_nbits = 0;

    // data changes only while the clock is low; ones shifted in release the line
    always @(negedge i_scl or posedge i_load)
    begin
        if (i_load)
        begin
            tx_sr_r <= i_tx;
            o_sda_oe <= 1'b0;
        end
        else
        begin
            o_sda_oe <= !tx_sr_r[7];
            tx_sr_r <= {tx_sr_r[6:0], 1'b1};
        end
    end

    always @(posedge i_scl)
    begin
        o_rx <= {o_rx[14:0], i_sda};
        o_nbits <= o_nbits + 1;
    end
endmodule // sbsync_peer

// ### tb/sbsync_top_tb.sv
`timescale 1ns/1ps
module sbsync_top_tb;
    import sbsync_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic o_scl_oe;
    logic o_sda_oe;
    sbsync_mode_t o_mode;
    logic o_busy;
    logic peer_oe;
    logic peer_load = 1'b0;
    logic [7:0] peer_tx = 8'hFF;
    logic [15:0] peer_rx;
    int peer_n;
    int n_mismatch = 0;
    int checks = 0;
    int n0;
    logic [7:0] d;
    logic bench_scl_low = 1'b0;
    // open-drain lines with pull-ups; the bench clocks the line in slave mode
    wire scl = !(o_scl_oe || bench_scl_low);
    wire sda = !(o_sda_oe || peer_oe);

    always #4 i_clock = !i_clock;

    sbsync_top #(.OTHER_DIV_RATIO(4)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_scl(scl), .o_scl(), .o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda(),
        .o_sda_oe(o_sda_oe), .o_mode(o_mode), .o_busy(o_busy));
    sbsync_peer peer (.i_scl(scl), .i_sda(sda), .i_load(peer_load), .i_tx(peer_tx),
        .o_sda_oe(peer_oe), .o_rx(peer_rx), .o_nbits(peer_n));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 4000 && o_busy !== 1'b0; k++) @(negedge i_clock);
        chk(8'(o_busy), 8'h00);
    endtask
    task automatic wait_bits(input int n);
        for (int k = 0; k < 4000 && peer_n < n; k++) @(negedge i_clock);
        chk(8'(peer_n - n), 8'h00);
    endtask
    task automatic finish_test();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic t_reset();
        logic [15:0] a [7] = '{ADDR_CTRL_PRIMARY, ADDR_MODE, ADDR_FORMAT, ADDR_TX_BUF,
            ADDR_RX_BUF, 16'hF000, ADDR_CTRL_PINS};
        logic [7:0] e [7] = '{RST_CTRL, 8'h00, 8'h00, RST_TX_BUF, RST_RX_BUF, 8'h00, 8'h30};
        for (int i = 0; i < 7; i++)
        begin
            rd(a[i]);
            chk((i == 6) ? (d & 8'h30) : d, e[i]);
        end
        $display("reset values done");
    endtask
    task automatic t_manual_sda();
        // manual level only while no frame runs
        wr(ADDR_CTRL_PRIMARY, 8'hA5);
        wr(ADDR_CTRL_PINS, 8'h00);
        rd(ADDR_CTRL_PINS);
        chk({d[5], 6'h00, o_sda_oe}, 8'h01);
        wr(ADDR_CTRL_PINS, 8'h30);
        rd(ADDR_CTRL_PINS);
        chk({d[5], 6'h00, o_sda_oe}, 8'h01);
        wr(ADDR_CTRL_PRIMARY, 8'h25);
        repeat (2) @(negedge i_clock);
        chk(8'(o_sda_oe), 8'h00);
        wr(ADDR_CTRL_PRIMARY, 8'hA5);
        wr(ADDR_CTRL_PINS, 8'h20);
        rd(ADDR_CTRL_PINS);
        chk({d[5], 6'h00, o_sda_oe}, 8'h80);
        $display("manual data line done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_CTRL_PRIMARY, 8'(m << 4) | 8'h05);
            repeat (2) @(negedge i_clock);
            chk(8'(o_mode), 8'(1 << m));
        end
        $display("mode decode done");
    endtask
    task automatic t_tx_pair();
        n0 = peer_n;
        wr(ADDR_CTRL_PRIMARY, 8'hB5);
        wr(ADDR_TX_BUF, 8'hA6);
        repeat (300) @(negedge i_clock);
        chk(8'(peer_n - n0), 8'h00);
        wr(ADDR_FORMAT, 8'h01);
        repeat (40) @(negedge i_clock);
        wr(ADDR_TX_BUF, 8'h3C);
        wait_bits(n0 + 16);
        wait_idle();
        chk(peer_rx[15:8], 8'hA6);
        chk(peer_rx[7:0], 8'h3C);
        $display("back to back transmit done");
    endtask
    task automatic t_rx();
        peer_tx = 8'h5B;
        peer_load = 1'b1;
        #1 peer_load = 1'b0;
        // direction flips only between frames
        wr(ADDR_CTRL_PRIMARY, 8'hA5);
        rd(ADDR_RX_BUF);
        repeat (4) @(negedge i_clock);
        chk(8'(o_busy), 8'h01);
        wait_idle();
        wr(ADDR_CTRL_PRIMARY, 8'hE5);
        wr(ADDR_RX_BUF, 8'h00);
        rd(ADDR_RX_BUF);
        chk(d, 8'h5B);
        repeat (300) @(negedge i_clock);
        chk(8'(o_busy), 8'h00);
        $display("master receive done");
    endtask
    task automatic t_lsb();
        wr(ADDR_CTRL_PRIMARY, 8'hB5);
        // bit order is only touched with the clocked format off
        wr(ADDR_FORMAT, 8'h00);
        wr(ADDR_MODE, 8'h80);
        wr(ADDR_FORMAT, 8'h01);
        n0 = peer_n;
        wr(ADDR_TX_BUF, 8'h1E);
        wait_bits(n0 + 8);
        wait_idle();
        chk(peer_rx[7:0], 8'h78);
        $display("lsb first transmit done");
    endtask
    task automatic t_slave_rx();
        peer_tx = 8'h35;
        peer_load = 1'b1;
        #1 peer_load = 1'b0;
        n0 = peer_n;
        // odd clock select on purpose: the far side owns the clock here
        wr(ADDR_CTRL_PRIMARY, 8'h8A);
        for (int b = 0; b < 16; b++)
        begin
            repeat (20) @(posedge i_clock);
            bench_scl_low <= !b[0];
        end
        repeat (20) @(posedge i_clock);
        chk(8'(peer_n - n0), 8'h08);
        chk(8'(o_scl_oe), 8'h00);
        rd(ADDR_RX_BUF);
        // still lsb first from the previous test
        chk(d, 8'hAC);
        wr(ADDR_CTRL_PRIMARY, 8'h00);
        repeat (2) @(negedge i_clock);
        chk(8'(o_busy), 8'h00);
        $display("slave receive done");
    endtask

    initial
    begin
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_reset();
        t_manual_sda();
        t_modes();
        t_tx_pair();
        t_rx();
        t_lsb();
        t_slave_rx();
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge i_clock);
        n_mismatch++;
        finish_test();
    end
endmodule // sbsync_top_tb
